// ### rtl/sep_eeprom.sv
// spi eeprom command decoder, write latch, status register and array
`timescale 1ns/1ps
// Summary of operation
// - opcode captured in 8-bit instruction register
// - serial input sampled on rising clock
// - everything shifted msb first
// - first bit on first rise after select
// - pause resumes at the same bit
// - write needs latch set at start
// - latch cleared at power-up and after writes
// - 06 sets latch, 04 clears it
// - 03 reads array, 02 writes array
// - 05 reads status, 01 writes status
// - status read allowed during write cycle
// - status byte layout pin-enable..busy
// - busy flag read only, high while writing
// - latch flag mirrors latch, gates writes
// - latch commands ignore hardware protection
// - block bits changed only by status write
// - hardware protect: pin low and enable
// - hardware protect blocks only status writes
// - protected blocks never written; status gated
// - write starts on select rise, within 5ms
// - block code selects none, quarter, half, all
// - commit only on whole byte boundary
// - read pointer increments and wraps
// - page write wraps within 16 bytes
module sep_eeprom #(
    parameter int ADDR_W       = sep_pkg::ADDR_W_DEF,
    parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES_DEF
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so,
    output logic      so_oe
);
    import sep_pkg::*;
    localparam int PG_W = $clog2(PAGE_BYTES);

    function automatic logic blk_protected(input logic [1:0] bp,
                                           input logic [ADDR_W-1:0] a);
        case (bp)
            BP_NONE:    blk_protected = 1'b0;
            BP_QUARTER: blk_protected = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
            BP_HALF:    blk_protected = a[ADDR_W-1];
            default:    blk_protected = 1'b1;
        endcase
    endfunction

    function automatic logic [7:0] status_byte(input logic [2:0] nv,
                                               input logic write_latch_flag,
                                               input logic bsy);
        status_byte              = 8'h00;
        status_byte[SR_PIN_EN]   = nv[2];
        status_byte[SR_BP_HI]    = nv[1];
        status_byte[SR_BP_LO]    = nv[0];
        status_byte[SR_LATCH]    = write_latch_flag;
        status_byte[SR_BUSY]     = bsy;
    endfunction

    // pin synchronisers
    logic [1:0] cs_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] si_sync_reg;
    logic [1:0] hold_sync_reg;
    logic [1:0] wp_sync_reg;
    logic       sck_prev_reg;
    logic       cs_prev_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cs_sync_reg   <= 2'h3;
            sck_sync_reg  <= 2'h0;
            si_sync_reg   <= 2'h0;
            hold_sync_reg <= 2'h3;
            wp_sync_reg   <= 2'h3;
            sck_prev_reg  <= 1'b0;
            cs_prev_reg   <= 1'b1;
        end else begin
            cs_sync_reg   <= {cs_sync_reg[0], cs_n};
            sck_sync_reg  <= {sck_sync_reg[0], sck};
            si_sync_reg   <= {si_sync_reg[0], si};
            hold_sync_reg <= {hold_sync_reg[0], hold_n};
            wp_sync_reg   <= {wp_sync_reg[0], wp_n};
            sck_prev_reg  <= sck_sync_reg[1];
            cs_prev_reg   <= cs_sync_reg[1];
        end
    end

    logic cs_act;
    logic cs_fall;
    logic cs_rise;
    logic run;
    logic sck_rise;
    logic sck_fall;
    logic si_s;
    logic hw_prot;

    assign cs_act   = !cs_sync_reg[1];
    assign cs_fall  = cs_act && cs_prev_reg;
    assign cs_rise  = cs_sync_reg[1] && !cs_prev_reg;
    assign run      = cs_act && !cs_fall && hold_sync_reg[1];
    assign sck_rise = run && sck_sync_reg[1] && !sck_prev_reg;
    assign sck_fall = run && !sck_sync_reg[1] && sck_prev_reg;
    assign si_s     = si_sync_reg[1];

    sep_wr_if wr ();

    sep_write_timer #(.WRITE_CYCLES(WRITE_CYCLES)) u_timer (
        .clock (clock),
        .rst_n (rst_n),
        .wr    (wr)
    );

    // pin enable and block protect bits survive reset
    logic [2:0]        nv_reg = NV_INIT;
    logic [2:0]        nv_next;
    logic [7:0]        mem [2**ADDR_W];
    logic [7:0]        page_buf [PAGE_BYTES];

    sep_state_e        state_reg;
    sep_state_e        state_next;
    logic [3:0]        bit_cnt_reg;
    logic [3:0]        bit_cnt_next;
    logic [7:0]        shift_reg;
    logic [7:0]        shift_next;
    logic [7:0]        instr_reg;
    logic [7:0]        instr_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [7:0]        out_sh_reg;
    logic [7:0]        out_sh_next;
    logic [2:0]        out_cnt_reg;
    logic [2:0]        out_cnt_next;
    logic              so_reg;
    logic              so_next;
    logic              so_oe_reg;
    logic              so_oe_next;
    logic              byte_done_reg;
    logic              byte_done_next;
    logic              wel_reg;
    logic              wel_next;
    logic [PAGE_BYTES-1:0] loaded_reg;
    logic [PAGE_BYTES-1:0] loaded_next;
    logic [7:0]        sr_data_reg;
    logic [7:0]        sr_data_next;
    logic              pend_sr_reg;
    logic              pend_sr_next;
    logic              start;
    logic              buf_we;
    logic [7:0]        rx_byte;
    logic [7:0]        status;

    assign rx_byte = {shift_reg[6:0], si_s};
    assign hw_prot = !wp_sync_reg[1] && nv_reg[2];
    assign status  = status_byte(nv_reg, wel_reg, wr.busy);
    assign wr.start = start;

    always_comb begin
        state_next     = state_reg;
        bit_cnt_next   = bit_cnt_reg;
        shift_next     = shift_reg;
        instr_next     = instr_reg;
        addr_next      = addr_reg;
        out_sh_next    = out_sh_reg;
        out_cnt_next   = out_cnt_reg;
        so_next        = so_reg;
        so_oe_next     = so_oe_reg;
        byte_done_next = byte_done_reg;
        wel_next       = wel_reg;
        loaded_next    = loaded_reg;
        sr_data_next   = sr_data_reg;
        pend_sr_next   = pend_sr_reg;
        nv_next        = nv_reg;
        start          = 1'b0;
        buf_we         = 1'b0;
        if (!cs_act) begin
            state_next = ST_IDLE;
            so_oe_next = 1'b0;
        end
        if (cs_fall) begin
            state_next     = ST_CMD;
            bit_cnt_next   = 4'h0;
            byte_done_next = 1'b0;
        end
        if (!hold_sync_reg[1]) begin
            so_oe_next = 1'b0;
        end
        if (sck_rise) begin
            shift_next     = rx_byte;
            bit_cnt_next   = bit_cnt_reg + 4'h1;
            byte_done_next = 1'b0;
            case (state_reg)
                ST_CMD: begin
                    if (bit_cnt_reg == 4'h7) begin
                        instr_next   = rx_byte;
                        bit_cnt_next = 4'h0;
                        state_next   = ST_IGNORE;
                        case (rx_byte)
                            OP_READ, OP_WRITE: begin
                                if (!wr.busy) begin
                                    state_next  = ST_ADDR;
                                    loaded_next = '0;
                                end
                            end
                            OP_STAT_READ: begin
                                state_next   = ST_SREAD;
                                out_sh_next  = status;
                                out_cnt_next = 3'h0;
                            end
                            OP_STAT_WRITE: begin
                                if (!wr.busy) begin
                                    state_next = ST_SWRITE;
                                end
                            end
                            OP_LATCH_SET, OP_LATCH_CLR: begin
                                byte_done_next = !wr.busy;
                            end
                            default: state_next = ST_IGNORE;
                        endcase
                    end
                end
                ST_ADDR: begin
                    addr_next = {addr_reg[ADDR_W-2:0], si_s};
                    if (bit_cnt_reg == 4'(ADDR_BITS - 1)) begin
                        bit_cnt_next = 4'h0;
                        if (instr_reg == OP_READ) begin
                            state_next   = ST_RDATA;
                            out_sh_next  = mem[addr_next];
                            out_cnt_next = 3'h0;
                        end else begin
                            state_next = ST_WDATA;
                        end
                    end
                end
                ST_WDATA: begin
                    if (bit_cnt_reg == 4'h7) begin
                        bit_cnt_next   = 4'h0;
                        buf_we         = 1'b1;
                        byte_done_next = 1'b1;
                        loaded_next[addr_reg[PG_W-1:0]] = 1'b1;
                        addr_next[PG_W-1:0] = addr_reg[PG_W-1:0] + 1'b1;
                    end
                end
                ST_SWRITE: begin
                    if (bit_cnt_reg == 4'h7) begin
                        bit_cnt_next   = 4'h0;
                        sr_data_next   = rx_byte;
                        byte_done_next = 1'b1;
                    end
                end
                default: bit_cnt_next = 4'h0;
            endcase
        end
        if (sck_fall && (state_reg == ST_RDATA || state_reg == ST_SREAD)) begin
            so_next      = out_sh_reg[7];
            so_oe_next   = 1'b1;
            out_sh_next  = {out_sh_reg[6:0], 1'b0};
            out_cnt_next = out_cnt_reg + 3'h1;
            if (out_cnt_reg == 3'h7) begin
                if (state_reg == ST_RDATA) begin
                    addr_next   = addr_reg + 1'b1;
                    out_sh_next = mem[addr_next];
                end else begin
                    out_sh_next = status;
                end
            end
        end
        if (cs_rise && byte_done_reg && !wr.busy) begin
            case (state_reg)
                ST_WDATA: begin
                    if (wel_reg && !blk_protected(nv_reg[1:0], addr_reg)) begin
                        start        = 1'b1;
                        pend_sr_next = 1'b0;
                    end
                end
                ST_SWRITE: begin
                    if (wel_reg && !hw_prot) begin
                        start        = 1'b1;
                        pend_sr_next = 1'b1;
                    end
                end
                ST_IGNORE: begin
                    wel_next = (instr_reg == OP_LATCH_SET);
                end
                default: wel_next = wel_reg;
            endcase
        end
        if (wr.done) begin
            wel_next = 1'b0;
            if (pend_sr_reg) begin
                nv_next = {sr_data_reg[SR_PIN_EN], sr_data_reg[SR_BP_HI:SR_BP_LO]};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 8'h00;
            instr_reg     <= 8'h00;
            addr_reg      <= '0;
            out_sh_reg    <= 8'h00;
            out_cnt_reg   <= 3'h0;
            so_reg        <= 1'b0;
            so_oe_reg     <= 1'b0;
            byte_done_reg <= 1'b0;
            wel_reg       <= 1'b0;
            loaded_reg    <= '0;
            sr_data_reg   <= 8'h00;
            pend_sr_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            bit_cnt_reg   <= bit_cnt_next;
            shift_reg     <= shift_next;
            instr_reg     <= instr_next;
            addr_reg      <= addr_next;
            out_sh_reg    <= out_sh_next;
            out_cnt_reg   <= out_cnt_next;
            so_reg        <= so_next;
            so_oe_reg     <= so_oe_next;
            byte_done_reg <= byte_done_next;
            wel_reg       <= wel_next;
            loaded_reg    <= loaded_next;
            sr_data_reg   <= sr_data_next;
            pend_sr_reg   <= pend_sr_next;
        end
        nv_reg <= nv_next;
    end

    // page buffer fills while shifting, array takes it at cycle end
    always_ff @(posedge clock) begin
        if (buf_we) begin
            page_buf[addr_reg[PG_W-1:0]] <= rx_byte;
        end
        if (wr.done && !pend_sr_reg) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (loaded_reg[i]) begin
                    mem[{addr_reg[ADDR_W-1:PG_W], PG_W'(i)}] <= page_buf[i];
                end
            end
        end
    end

    assign so    = so_reg;
    assign so_oe = so_oe_reg;

    property p_instr_capture;
        @(posedge clock) disable iff (!rst_n)
        (sck_rise && state_reg == ST_CMD && bit_cnt_reg == 4'h7)
            |=> instr_reg == $past(rx_byte);
    endproperty
    a_instr_capture: assert property (p_instr_capture) else $error("opcode not captured");

    property p_start_needs_latch;
        @(posedge clock) disable iff (!rst_n)
        start |-> wel_reg && cs_rise && byte_done_reg;
    endproperty
    a_start_needs_latch: assert property (p_start_needs_latch) else $error("bad write start");

    property p_latch_clear_done;
        @(posedge clock) disable iff (!rst_n)
        wr.done |=> !wel_reg;
    endproperty
    a_latch_clear_done: assert property (p_latch_clear_done) else $error("latch kept");

    property p_latch_set;
        @(posedge clock) disable iff (!rst_n)
        (cs_rise && state_reg == ST_IGNORE && byte_done_reg && instr_reg == OP_LATCH_SET)
            |=> wel_reg;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set");

    property p_sr_protect;
        @(posedge clock) disable iff (!rst_n)
        (start && state_reg == ST_SWRITE) |-> !hw_prot;
    endproperty
    a_sr_protect: assert property (p_sr_protect) else $error("status write while protected");

    property p_hold_keeps_bit;
        @(posedge clock) disable iff (!rst_n)
        (!hold_sync_reg[1] && cs_act && !cs_prev_reg) |=> $stable(bit_cnt_reg) || !cs_act;
    endproperty
    a_hold_keeps_bit: assert property (p_hold_keeps_bit) else $error("bit lost in pause");

    property p_read_advance;
        @(posedge clock) disable iff (!rst_n)
        (sck_fall && state_reg == ST_RDATA && out_cnt_reg == 3'h7)
            |=> addr_reg == $past(addr_reg) + 1'b1;
    endproperty
    a_read_advance: assert property (p_read_advance) else $error("pointer not advanced");

    property p_page_wrap;
        @(posedge clock) disable iff (!rst_n)
        buf_we |=> addr_reg[ADDR_W-1:PG_W] == $past(addr_reg[ADDR_W-1:PG_W]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page left");
endmodule

// ### rtl/sep_pkg.sv
// constants for the spi eeprom command and protection block
package sep_pkg;
    localparam int ADDR_W_DEF    = 10;
    localparam int ADDR_BITS     = 16;
    localparam int PAGE_BYTES    = 16;
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_WC_MS       = 5;
    localparam int WRITE_CYCLES_DEF = T_WC_MS * 1000000 / CLK_PERIOD_NS;

    localparam logic [7:0] OP_LATCH_SET  = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR  = 8'h04;
    localparam logic [7:0] OP_STAT_READ  = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE = 8'h01;
    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_WRITE      = 8'h02;

    localparam int SR_PIN_EN  = 7;
    localparam int SR_BP_HI   = 3;
    localparam int SR_BP_LO   = 2;
    localparam int SR_LATCH   = 1;
    localparam int SR_BUSY    = 0;

    // factory value of pin enable and block protect bits
    localparam logic [2:0] NV_INIT = 3'h0;

    localparam logic [1:0] BP_NONE    = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF    = 2'h2;
    localparam logic [1:0] BP_ALL     = 2'h3;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_CMD    = 8'h02,
        ST_ADDR   = 8'h04,
        ST_RDATA  = 8'h08,
        ST_WDATA  = 8'h10,
        ST_SREAD  = 8'h20,
        ST_SWRITE = 8'h40,
        ST_IGNORE = 8'h80
    } sep_state_e;
endpackage

// ### rtl/sep_wr_if.sv
// start and completion handshake of the self-timed write cycle
`timescale 1ns/1ps
interface sep_wr_if;
    logic start;
    logic busy;
    logic done;
    modport ctl (output start, input busy, input done);
    modport tmr (input start, output busy, output done);
endinterface

// ### rtl/sep_write_timer.sv
// self-timed internal write cycle counter
`timescale 1ns/1ps
module sep_write_timer #(
    parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    sep_wr_if.tmr    wr
);
    import sep_pkg::*;
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          busy_reg;
    logic          busy_next;
    logic          done_reg;
    logic          done_next;

    always_comb begin
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (!busy_reg && wr.start) begin
            cnt_next  = CW'(WRITE_CYCLES);
            busy_next = 1'b1;
        end else if (busy_reg) begin
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == CW'(1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign wr.busy = busy_reg;
    assign wr.done = done_reg;

    property p_wc_bound;
        @(posedge clock) disable iff (!rst_n)
        cnt_reg <= CW'(WRITE_CYCLES);
    endproperty
    a_wc_bound: assert property (p_wc_bound) else $error("write cycle count too long");

    property p_wc_start;
        @(posedge clock) disable iff (!rst_n)
        (wr.start && !busy_reg) |=> busy_reg && cnt_reg == CW'(WRITE_CYCLES);
    endproperty
    a_wc_start: assert property (p_wc_start) else $error("write cycle did not start");
endmodule

// ### tb/sep_spi_host.sv
// spi master model driving the eeprom pins
`timescale 1ns/1ps
module sep_spi_host (
    input  wire logic       clock,
    input  wire logic       so,
    output logic            cs_n,
    output logic            sck,
    output logic            si,
    output logic            hold_n,
    output logic [7:0]      rx_byte,
    output logic            rx_stb
);
    initial begin
        cs_n    = 1'b1;
        sck     = 1'b0;
        si      = 1'b0;
        hold_n  = 1'b1;
        rx_byte = 8'h00;
        rx_stb  = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic sel();
        step(1);
        cs_n = 1'b0;
        step(4);
    endtask
    // released data line shows the inverse of its last bit
    task automatic desel();
        step(4);
        cs_n = 1'b1;
        si   = ~si;
        step(6);
    endtask
    // nb bits msb first, pause with a stray clock before bit hp
    task automatic xfer(input logic [7:0] tx, input int nb, input int hp,
                        input bit chk);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            si = tx[i];
            if (i == hp) begin
                hold_n = 1'b0;
                step(4);
                sck = 1'b1;
                step(4);
                sck = 1'b0;
                step(4);
                hold_n = 1'b1;
            end
            step(5);
            sck  = 1'b1;
            r[i] = so;
            step(5);
            sck = 1'b0;
        end
        if (chk) begin
            rx_byte = r;
            rx_stb  = 1'b1;
            step(1);
            rx_stb = 1'b0;
        end
    endtask
endmodule

// ### tb/tb_sep_eeprom.sv
// self-checking bench for the spi eeprom command block
`timescale 1ns/1ps
module tb_sep_eeprom;
    import sep_pkg::*;
    localparam int WCYC = 400;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       wp_n  = 1'b1;
    logic       cs_n, sck, si, hold_n, so, so_oe, rx_stb;
    logic [7:0] rx_byte, a, b, c, d;
    logic [7:0] shadow [4];
    logic [7:0] exp_q [$];
    int         seed = 89348;
    int         n_errors = 0;
    int         n_compared = 0;

    always #4 clock = ~clock;

    sep_eeprom #(.ADDR_W(10), .WRITE_CYCLES(WCYC)) dut (
        .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe)
    );
    // a released output reads as the inverse of its last value
    sep_spi_host host (
        .clock(clock), .so(so_oe ? so : ~so), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .rx_byte(rx_byte), .rx_stb(rx_stb)
    );

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] e);
        n_compared++;
        if (seen !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, seen);
        end
    endtask
    always @(posedge clock) begin
        if (rx_stb === 1'b1) begin
            check("so byte", rx_byte, exp_q.pop_front());
        end
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tx(input logic [7:0] v);
        host.xfer(v, 8, 8, 1'b0);
    endtask
    task automatic rx(input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(8'($random(seed)), 8, 8, 1'b1);
    endtask
    task automatic cmd(input logic [7:0] op);
        host.sel();
        tx(op);
        host.desel();
    endtask
    task automatic hdr(input logic [7:0] op, input logic [15:0] ad, input int hp);
        host.sel();
        tx(op);
        tx(ad[15:8]);
        host.xfer(ad[7:0], 8, hp, 1'b0);
    endtask
    task automatic settle();
        repeat (WCYC + 20) @(posedge clock);
        #1;
    endtask
    task automatic sr_rd(input logic [7:0] e);
        host.sel();
        tx(OP_STAT_READ);
        rx(e);
        host.desel();
    endtask
    task automatic sr_wr(input logic [7:0] v);
        cmd(OP_LATCH_SET);
        host.sel();
        tx(OP_STAT_WRITE);
        tx(v);
        host.desel();
    endtask
    task automatic wr1(input logic [15:0] ad, input logic [7:0] v);
        cmd(OP_LATCH_SET);
        hdr(OP_WRITE, ad, 8);
        tx(v);
        host.desel();
        settle();
    endtask
    task automatic rd1(input logic [15:0] ad, input logic [7:0] e);
        hdr(OP_READ, ad, 8);
        rx(e);
        host.desel();
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        host.step(4);
        sr_rd(8'h00);
        cmd(OP_LATCH_SET);
        sr_rd(8'h02);
        cmd(OP_LATCH_CLR);
        sr_rd(8'h00);
        sr_wr(8'h7C);
        sr_rd(8'h03);
        settle();
        sr_rd(8'h0C);
        $display("latch and status test done");
        for (int bp = 0; bp < 4; bp++) begin
            sr_wr({4'h0, 2'(bp), 2'h0});
            settle();
            sr_rd({4'h0, 2'(bp), 2'h0});
            for (int k = 1; k < 4; k++) begin
                d = 8'($random(seed));
                wr1(16'(k * 256), d);
                if (bp < 4 - k) shadow[k] = d;
                cmd(OP_LATCH_CLR);
                rd1(16'(k * 256), shadow[k]);
            end
        end
        $display("block protect test done");
        sr_wr(8'h00);
        settle();
        {a, b, c, d} = $random(seed);
        wr1(16'h03FF, d);
        cmd(OP_LATCH_SET);
        hdr(OP_WRITE, 16'h000E, 8);
        tx(a);
        tx(b);
        tx(c);
        host.desel();
        settle();
        hdr(OP_READ, 16'h03FF, 8);
        rx(d);
        rx(c);
        host.desel();
        hdr(OP_READ, 16'h000E, 3);
        rx(a);
        rx(b);
        host.desel();
        hdr(OP_WRITE, 16'h000E, 8);
        tx(~a);
        host.desel();
        settle();
        rd1(16'h000E, a);
        cmd(OP_LATCH_SET);
        hdr(OP_WRITE, 16'h000E, 8);
        tx(~a);
        host.xfer(a, 3, 8, 1'b0);
        host.desel();
        settle();
        sr_rd(8'h02);
        rd1(16'h000E, a);
        $display("array test done");
        sr_wr(8'h80);
        settle();
        wp_n = 1'b0;
        sr_wr(8'h8C);
        settle();
        sr_rd(8'h82);
        rst_n = 1'b0;
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        host.step(4);
        sr_rd(8'h80);
        wr1(16'h000E, b);
        rd1(16'h000E, b);
        wp_n = 1'b1;
        sr_wr(8'h00);
        settle();
        sr_rd(8'h00);
        $display("write protect test done");
        print_verdict();
    end
endmodule
